// ### rtl/e1_sa_bit_auto_response.sv
// transmit e1 overhead override on receive alarms and sa4 sourcing from a register
//
// Operation
// - with the first ais enable set and ais seen on receive, send a=1, sa5=1, sa6=1111.
// - with the second ais enable set and ais seen on receive, send a=0, sa5=1, sa6=1111.
// - a received e bit of 0 marks a far end block error, which triggers the report field.
// - report field 01 with a far end block error sends a=0, sa5=1, sa6=0000, e=0.
// - report field 10 with a far end block error sends a=0, sa5=0, sa6=0000, e=0.
// - report field 11 with a far end block error sends a=0, sa5=1, sa6=0001, e=1.
// - crc detection enabled with a local crc-4 error sends a=0, sa5=1, sa6=0010, e=1.
// - combined enable with both error kinds sends a=0, sa5=1, sa6=0011, e=1.
// - sa4 comes from the pattern register only when link enable and register select are 1.
// - pattern bit 7 goes in frame 1 of the multiframe, bit 6 in frame 3, down to bit 0 in frame 15.
`timescale 1ns/1ps
`include "e1_sa_params.svh"

module e1_sa_bit_auto_response
  import e1_sa_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic [`ADDR_W-1:0]  paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // receive side conditions
  input  wire logic                rx_ais_detect,
  input  wire logic                rx_e_valid,
  input  wire logic                rx_e_bit,
  input  wire logic                rx_crc_err,
  // transmit frame stream in
  input  wire logic                tx_in_valid,
  output logic                     tx_in_ready,
  input  wire logic [`FRAME_W-1:0] tx_in_frame,
  input  wire logic                tx_in_a,
  input  wire logic                tx_in_sa4,
  input  wire logic                tx_in_sa5,
  input  wire logic                tx_in_sa6,
  input  wire logic                tx_in_e,
  // transmit frame stream out
  output logic                     tx_out_valid,
  input  wire logic                tx_out_ready,
  output logic [`FRAME_W-1:0]      tx_out_frame,
  output logic                     tx_out_a,
  output logic                     tx_out_sa4,
  output logic                     tx_out_sa5,
  output logic                     tx_out_sa6,
  output logic                     tx_out_e
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // bit of an eight-bit pattern for an odd frame index 1,3..15
  function automatic logic mf_bit(input logic [7:0] pat, input logic [`FRAME_W-1:0] fr);
    logic [2:0] pos;
    pos = 3'd7 - fr[3:1];
    return pat[pos];
  endfunction : mf_bit

  // bit of a sa6 nibble for an odd frame within its sub-multiframe
  function automatic logic nib_bit(input logic [3:0] nib, input logic [`FRAME_W-1:0] fr);
    logic [1:0] pos;
    pos = 2'd3 - fr[2:1];
    return nib[pos];
  endfunction : nib_bit

  // register index decode
  function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [`ADDR_W-1:0] idx);
    return (addr[`ADDR_W-1:`IDX_LSB] == idx[`ADDR_W-`IDX_LSB-1:0])
           && (addr[`IDX_LSB-1:0] == 2'b00);
  endfunction : hit

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  auto_ctrl_r;
  logic [7:0]  sa4_pattern_r;
  logic        sa4_link_en_r;
  logic        sa4_reg_sel_r;
  logic        febe_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire hit_link   = hit(paddr, `IDX_LINK_CTRL);
  wire hit_sel    = hit(paddr, `IDX_SRC_SEL);
  wire hit_ctrl   = hit(paddr, `IDX_AUTO_CTRL);
  wire hit_pat    = hit(paddr, `IDX_SA4_PATTERN);
  wire hit_stat   = hit(paddr, `IDX_RESP_STATUS);
  wire hit_any    = hit_link | hit_sel | hit_ctrl | hit_pat | hit_stat;
  wire setup_ph   = psel & ~penable;
  wire access_end = psel & penable & pready_r;
  wire wr_en      = access_end & pwrite & ~pslverr_r;

  // ****************************************************************
  // control field decode
  // ****************************************************************
  wire       ais_set_en   = auto_ctrl_r[`F_AIS_SET];
  wire       ais_clr_en   = auto_ctrl_r[`F_AIS_CLR];
  wire [1:0] rep_sel      = auto_ctrl_r[`F_REP_HI:`F_REP_LO];
  wire       crc_det_en   = auto_ctrl_r[`F_CRC_DET];
  wire       combined_en  = auto_ctrl_r[`F_COMBINED];

  // ****************************************************************
  // trigger conditions
  // ****************************************************************

  // far end block error: e bit of 0 sets, e bit of 1 clears
  wire febe_set = rx_e_valid & ~rx_e_bit;
  wire febe_clr = rx_e_valid & rx_e_bit;

  // ais and crc are levels from the receive framer
  wire trig_ais  = rx_ais_detect;
  wire trig_crc  = rx_crc_err;
  wire trig_febe = febe_r;

  // ****************************************************************
  // response selection, highest first: ais set, ais clear,
  // combined, crc detect, far end report
  // ****************************************************************
  resp_t resp;
  assign resp =
      (ais_set_en & trig_ais)                  ? RESP_AIS_SET  :
      (ais_clr_en & trig_ais)                  ? RESP_AIS_CLR  :
      (combined_en & trig_febe & trig_crc)     ? RESP_COMBINED :
      (crc_det_en & trig_crc)                  ? RESP_CRC_DET  :
      (trig_febe & (rep_sel == `REP_01))       ? RESP_REP_01   :
      (trig_febe & (rep_sel == `REP_10))       ? RESP_REP_10   :
      (trig_febe & (rep_sel == `REP_11))       ? RESP_REP_11   :
                                                 RESP_NONE;

  // ****************************************************************
  // override pattern table
  // ****************************************************************
  logic       ov_on;
  logic       ov_a;
  logic       ov_sa5;
  logic [3:0] ov_sa6;
  logic       ov_e_on;
  logic       ov_e;

  // pattern per response; ais leaves the e bit alone
  always_comb begin
    ov_on   = 1'b1;
    ov_a    = 1'b0;
    ov_sa5  = 1'b1;
    ov_sa6  = `SA6_ZERO;
    ov_e_on = 1'b1;
    ov_e    = 1'b0;
    unique case (resp)
      RESP_NONE: begin
        ov_on   = 1'b0;
        ov_e_on = 1'b0;
      end
      RESP_AIS_SET: begin
        ov_a    = 1'b1;
        ov_sa6  = `SA6_ONES;
        ov_e_on = 1'b0;
      end
      RESP_AIS_CLR: begin
        ov_sa6  = `SA6_ONES;
        ov_e_on = 1'b0;
      end
      RESP_REP_01: begin
        ov_sa6  = `SA6_ZERO;
      end
      RESP_REP_10: begin
        ov_sa5  = 1'b0;
      end
      RESP_REP_11: begin
        ov_sa6  = `SA6_REP11;
        ov_e    = 1'b1;
      end
      RESP_CRC_DET: begin
        ov_sa6  = `SA6_CRC;
        ov_e    = 1'b1;
      end
      RESP_COMBINED: begin
        ov_sa6  = `SA6_BOTH;
        ov_e    = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // overhead merge on the incoming frame
  // ****************************************************************

  // sa bits and the a bit live in frames without alignment word
  wire nfas_frame = tx_in_frame[0];
  wire e_frame    = (tx_in_frame == `E_FRAME_A) | (tx_in_frame == `E_FRAME_B);
  wire sa4_from_r = sa4_link_en_r & sa4_reg_sel_r;

  wire merged_a   = (ov_on & nfas_frame) ? ov_a : tx_in_a;
  wire merged_sa4 = (sa4_from_r & nfas_frame)
                    ? mf_bit(sa4_pattern_r, tx_in_frame)
                    : tx_in_sa4;
  wire merged_sa5 = (ov_on & nfas_frame) ? ov_sa5 : tx_in_sa5;
  wire merged_sa6 = (ov_on & nfas_frame) ? nib_bit(ov_sa6, tx_in_frame) : tx_in_sa6;
  wire merged_e   = (ov_e_on & e_frame) ? ov_e : tx_in_e;

  wire [`WORD_W-1:0] in_word = {tx_in_frame, merged_a, merged_sa4,
                                merged_sa5, merged_sa6, merged_e};
  wire [`WORD_W-1:0] out_word;

  // ****************************************************************
  // output buffer, absorbs a stall without loss
  // ****************************************************************
  two_entry_buffer #(
    .WIDTH     (`WORD_W)
  ) u_out_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (in_word),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (out_word)
  );

  assign tx_out_frame = out_word[`WORD_W-1:`WORD_W-`FRAME_W];
  assign tx_out_a     = out_word[4];
  assign tx_out_sa4   = out_word[3];
  assign tx_out_sa5   = out_word[2];
  assign tx_out_sa6   = out_word[1];
  assign tx_out_e     = out_word[0];

  // ****************************************************************
  // far end block error hold
  // ****************************************************************

  // held from an e=0 until an e=1 is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      febe_r <= `RST_FLAG;
    end else if (febe_set) begin
      febe_r <= 1'b1;
    end else if (febe_clr) begin
      febe_r <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************

  // reserved control bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ctrl_r   <= `RST_AUTO_CTRL;
      sa4_pattern_r <= `RST_SA4_PATTERN;
      sa4_link_en_r <= `RST_FLAG;
      sa4_reg_sel_r <= `RST_FLAG;
    end else if (wr_en) begin
      if (hit_ctrl) auto_ctrl_r <= pwdata[7:0] & `CTRL_WR_MASK;
      if (hit_pat)  sa4_pattern_r <= pwdata[7:0];
      if (hit_link) sa4_link_en_r <= pwdata[`F_SA4_LINK_EN];
      if (hit_sel)  sa4_reg_sel_r <= pwdata[`F_SA4_REG_SEL];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl) rd_word[7:0] = auto_ctrl_r;
    if (hit_pat)  rd_word[7:0] = sa4_pattern_r;
    if (hit_link) rd_word[`F_SA4_LINK_EN] = sa4_link_en_r;
    if (hit_sel)  rd_word[`F_SA4_REG_SEL] = sa4_reg_sel_r;
    if (hit_stat) rd_word[5:0] = {trig_crc, trig_febe, trig_ais, resp};
  end

  // ****************************************************************
  // apb answer: ready in the first access cycle
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~hit_any;
      prdata_r  <= (setup_ph & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

endmodule : e1_sa_bit_auto_response

// ### rtl/e1_sa_params.svh
// named offsets, field positions, reset values and patterns for the sa auto-response block
`ifndef E1_SA_PARAMS_SVH
`define E1_SA_PARAMS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_LINK_CTRL      12'h10A
`define IDX_SRC_SEL        12'h130
`define IDX_AUTO_CTRL      12'h132
`define IDX_SA4_PATTERN    12'h133
`define IDX_RESP_STATUS    12'h134
`define ADDR_W             12
`define IDX_LSB            2

// ****************************************************************
// field positions
// ****************************************************************
`define F_AIS_SET          7
`define F_AIS_CLR          6
`define F_REP_HI           3
`define F_REP_LO           2
`define F_CRC_DET          1
`define F_COMBINED         0
`define F_SA4_LINK_EN      0
`define F_SA4_REG_SEL      0
`define CTRL_WR_MASK       8'hCF

// ****************************************************************
// reset values
// ****************************************************************
`define RST_AUTO_CTRL      8'h00
`define RST_SA4_PATTERN    8'hFF
`define RST_FLAG           1'b0

// ****************************************************************
// report field codes and sa6 nibbles
// ****************************************************************
`define REP_OFF            2'h0
`define REP_01             2'h1
`define REP_10             2'h2
`define REP_11             2'h3
`define SA6_ONES           4'hF
`define SA6_ZERO           4'h0
`define SA6_REP11          4'h1
`define SA6_CRC            4'h2
`define SA6_BOTH           4'h3

// ****************************************************************
// frame stream layout
// ****************************************************************
`define FRAME_W            4
`define WORD_W             9
`define E_FRAME_A          4'hD
`define E_FRAME_B          4'hF
`define BUF_DEPTH          2

`endif

// ### rtl/e1_sa_pkg.sv
// types shared by the sa auto-response block
package e1_sa_pkg;

  // ****************************************************************
  // active overhead response
  // ****************************************************************
  typedef enum logic [2:0] {
    RESP_NONE     = 3'b000,
    RESP_AIS_SET  = 3'b001,
    RESP_AIS_CLR  = 3'b010,
    RESP_REP_01   = 3'b011,
    RESP_REP_10   = 3'b100,
    RESP_REP_11   = 3'b101,
    RESP_CRC_DET  = 3'b110,
    RESP_COMBINED = 3'b111
  } resp_t;

endpackage : e1_sa_pkg

// ### rtl/two_entry_buffer.sv
// two-entry buffer with registered valid and ready on both sides
`timescale 1ns/1ps
`include "e1_sa_params.svh"

module two_entry_buffer
  import e1_sa_pkg::*;
#(
  parameter int WIDTH = `WORD_W
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // entry 0 faces the output, entry 1 catches a word during a stall
  logic [WIDTH-1:0] data_r  [`BUF_DEPTH];
  logic             valid_r [`BUF_DEPTH];
  logic             ready_r;

  // ****************************************************************
  // handshake decode
  // ****************************************************************
  wire in_fire   = in_valid & ready_r;
  wire head_free = ~valid_r[0] | out_ready;
  wire load_head = head_free & (valid_r[1] | in_fire);
  wire load_skid = ~head_free & in_fire;
  wire skid_nxt  = load_skid | (valid_r[1] & ~head_free);

  // head entry: from skid first, so order is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r[0]  <= '0;
      valid_r[0] <= 1'b0;
    end else if (head_free) begin
      valid_r[0] <= valid_r[1] | in_fire;
      if (load_head) begin
        data_r[0] <= valid_r[1] ? data_r[1] : in_data;
      end
    end
  end

  // skid entry and registered ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r[1]  <= '0;
      valid_r[1] <= 1'b0;
      ready_r    <= 1'b0;
    end else begin
      valid_r[1] <= skid_nxt;
      ready_r    <= ~skid_nxt;
      if (load_skid) begin
        data_r[1] <= in_data;
      end
    end
  end

  assign in_ready  = ready_r;
  assign out_valid = valid_r[0];
  assign out_data  = data_r[0];

endmodule : two_entry_buffer

// ### tb/e1_line_sink.sv
// line sink model: takes merged words, stalls on request
`timescale 1ns/1ps

module e1_line_sink (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // stall request and merged stream
  input  wire logic       stall_en,
  input  wire logic       tx_out_valid,
  output logic            tx_out_ready,
  input  wire logic [8:0] tx_out_word,
  // each word taken, one pulse
  output logic            got_valid,
  output logic [8:0]      got_word
);
  logic [15:0] lfsr_r;

  // ready steady or mostly low; word captured at its taking edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r       <= 16'hACE1;
      tx_out_ready <= 1'b0;
      got_valid    <= 1'b0;
      got_word     <= 9'h000;
    end else begin
      lfsr_r       <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      tx_out_ready <= !stall_en || (lfsr_r[1:0] == 2'h0);
      got_valid    <= tx_out_valid && tx_out_ready;
      got_word     <= tx_out_word;
    end
  end
endmodule : e1_line_sink

// ### tb/e1_sa_chk.sv
// port checker for the sa auto-response block
`timescale 1ns/1ps
`include "e1_sa_params.svh"

module e1_sa_chk (
  // apb
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // receive conditions and streams
  input wire logic        rx_ais_detect, rx_e_valid, rx_e_bit, rx_crc_err,
  input wire logic        tx_in_valid, tx_in_ready, tx_in_a, tx_in_sa4, tx_in_sa5,
  input wire logic        tx_in_sa6, tx_in_e, tx_out_valid, tx_out_ready, tx_out_a,
  input wire logic        tx_out_sa4, tx_out_sa5, tx_out_sa6, tx_out_e,
  input wire logic [3:0]  tx_in_frame, tx_out_frame
);
  localparam logic [13:0] ctrl_a  = {`IDX_AUTO_CTRL, 2'h0};
  localparam logic [3:0]  crc_nib = `SA6_CRC;
  logic [7:0] ctrl_r;
  logic       febe_r;
  logic [1:0] cnt_r;
  // next output word is the one accepted now
  wire        acc = tx_in_valid && tx_in_ready;
  wire        drn = tx_out_valid && tx_out_ready;
  wire        nxt = acc && (cnt_r == 2'h0 || (cnt_r == 2'h1 && drn));
  wire        odd = tx_in_frame[0];
  wire        hi  = rx_ais_detect && (ctrl_r[7] || ctrl_r[6]);
  wire [1:0]  nib = 2'h3 - tx_in_frame[2:1];
  wire [8:0]  w_in  = {tx_in_frame, tx_in_a, tx_in_sa4, tx_in_sa5, tx_in_sa6, tx_in_e};
  wire [8:0]  w_out = {tx_out_frame, tx_out_a, tx_out_sa4, tx_out_sa5, tx_out_sa6, tx_out_e};

  // shadow of control, far-end error and buffer fill
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `RST_AUTO_CTRL;
      febe_r <= 1'b0;
      cnt_r  <= 2'h0;
    end else begin
      if (psel && penable && pready && pwrite && !pslverr && paddr == ctrl_a[11:0])
        ctrl_r <= pwdata[7:0] & `CTRL_WR_MASK;
      if (rx_e_valid)
        febe_r <= !rx_e_bit;
      cnt_r <= cnt_r + 2'(acc) - 2'(drn);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_one; psel && !penable |=> pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("no pready after setup");
  property p_out_hold; tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(w_out); endproperty
  a_out_hold: assert property (p_out_hold) else $error("output word moved in stall");
  property p_full; cnt_r == 2'h2 |-> !tx_in_ready; endproperty
  a_full: assert property (p_full) else $error("full buffer still ready");
  property p_even; nxt && !odd |=> w_out == $past(w_in); endproperty
  a_even: assert property (p_even) else $error("even frame altered");
  property p_ais_set; nxt && odd && rx_ais_detect && ctrl_r[7]
    |=> tx_out_a && tx_out_sa5 && tx_out_sa6 && tx_out_e == $past(tx_in_e); endproperty
  a_ais_set: assert property (p_ais_set) else $error("ais set pattern wrong");
  property p_ais_clr; nxt && odd && rx_ais_detect && ctrl_r[6] && !ctrl_r[7]
    |=> !tx_out_a && tx_out_sa5 && tx_out_sa6; endproperty
  a_ais_clr: assert property (p_ais_clr) else $error("ais clear pattern wrong");
  property p_crc; nxt && odd && rx_crc_err && ctrl_r[1] && !hi && !(febe_r && ctrl_r[0])
    |=> !tx_out_a && tx_out_sa5 && tx_out_sa6 == crc_nib[$past(nib)]; endproperty
  a_crc: assert property (p_crc) else $error("crc detect pattern wrong");
  property p_rep10; nxt && odd && febe_r && ctrl_r[3:2] == 2'h2 && !hi
    && !(rx_crc_err && (ctrl_r[1] || ctrl_r[0])) |=> !tx_out_a && !tx_out_sa5 && !tx_out_sa6;
  endproperty
  a_rep10: assert property (p_rep10) else $error("report 10 pattern wrong");
endmodule : e1_sa_chk

bind e1_sa_bit_auto_response e1_sa_chk chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata,
  .rx_ais_detect, .rx_e_valid, .rx_e_bit, .rx_crc_err, .tx_in_valid, .tx_in_ready,
  .tx_in_a, .tx_in_sa4, .tx_in_sa5, .tx_in_sa6, .tx_in_e, .tx_out_valid, .tx_out_ready,
  .tx_out_a, .tx_out_sa4, .tx_out_sa5, .tx_out_sa6, .tx_out_e, .tx_in_frame, .tx_out_frame
);

// ### tb/tb_e1_sa_bit_auto_response.sv
// bench for the sa auto-response block with line sink and behavioural model
`timescale 1ns/1ps
`include "e1_sa_params.svh"

module tb_e1_sa_bit_auto_response;
  logic        pclk, presetn, psel, penable, pwrite, rx_ais_detect, rx_e_valid, rx_e_bit;
  logic        rx_crc_err, tx_in_valid, stall_en;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  tx_in_frame;
  logic [4:0]  in_bits;
  wire  [31:0] prdata;
  wire         pready, pslverr, tx_in_ready, tx_out_valid, tx_out_ready, got_valid;
  wire  [3:0]  tx_out_frame;
  wire  [4:0]  out_bits;
  wire  [8:0]  got_word;
  int          n_errors, checks_done, m_ctrl, m_pat, m_sa4, m_ais, m_crc, m_febe;
  logic [15:0] lfsr_q;
  logic [8:0]  exp_q[$];
  localparam logic [7:0] resp_a = 8'h02, resp_5 = 8'hEE, resp_e = 8'hE0;
  localparam logic [3:0] resp_6 [8] = '{`SA6_ZERO, `SA6_ONES, `SA6_ONES, `SA6_ZERO,
    `SA6_ZERO, `SA6_REP11, `SA6_CRC, `SA6_BOTH};
  localparam logic [7:0] ctrl_tab [10] = '{8'h30, 8'h8F, 8'h43, 8'h0F, 8'h06, 8'h04,
    8'h08, 8'h0C, 8'h0C, 8'h02};
  localparam logic [2:0] trig_tab [10] = '{3'h6, 3'h6, 3'h6, 3'h2, 3'h2, 3'h0, 3'h0,
    3'h0, 3'h1, 3'h1};

  e1_sa_bit_auto_response uut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .rx_ais_detect, .rx_e_valid, .rx_e_bit, .rx_crc_err, .tx_in_valid, .tx_in_ready,
    .tx_in_frame, .tx_in_a(in_bits[4]), .tx_in_sa4(in_bits[3]), .tx_in_sa5(in_bits[2]),
    .tx_in_sa6(in_bits[1]), .tx_in_e(in_bits[0]), .tx_out_valid, .tx_out_ready,
    .tx_out_frame, .tx_out_a(out_bits[4]), .tx_out_sa4(out_bits[3]),
    .tx_out_sa5(out_bits[2]), .tx_out_sa6(out_bits[1]), .tx_out_e(out_bits[0])
  );
  e1_line_sink sink (
    .pclk, .presetn, .stall_en, .tx_out_valid, .tx_out_ready,
    .tx_out_word({tx_out_frame, out_bits}), .got_valid, .got_word
  );

  // 125 mhz clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] ba(logic [11:0] idx);
    return idx << `IDX_LSB;
  endfunction : ba
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic ex_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk(32'(err), 32'(ex_err));
  endtask : rdchk
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ba(idx), d, rd, err);
    chk(32'(err), 32'h0000_0000);
  endtask : wr
  // receive levels plus one e-bit pulse, then settle
  task automatic set_trig(input logic [2:0] t);
    @(posedge pclk);
    rx_ais_detect <= t[2];
    rx_crc_err <= t[1];
    rx_e_bit <= t[0];
    rx_e_valid <= 1'b1;
    @(posedge pclk);
    rx_e_valid <= 1'b0;
    repeat (2) @(posedge pclk);
    m_ais = t[2];
    m_crc = t[1];
    m_febe = !t[0];
  endtask : set_trig
  // model: response chosen by fixed priority
  function automatic int resp_code();
    if (m_ais && m_ctrl[7]) return 1;
    if (m_ais && m_ctrl[6]) return 2;
    if (m_febe && m_crc && m_ctrl[0]) return 7;
    if (m_crc && m_ctrl[1]) return 6;
    if (m_febe && m_ctrl[3:2] != 0) return 2 + m_ctrl[3:2];
    return 0;
  endfunction : resp_code
  function automatic logic [8:0] exp_word(int f, logic [4:0] ib);
    int c;
    c = resp_code();
    if (f % 2 == 1) begin
      if (m_sa4 != 0) ib[3] = m_pat[7 - f / 2];
      if (c != 0) begin
        ib[4] = resp_a[c];
        ib[2] = resp_5[c];
        ib[1] = resp_6[c][3 - (f / 2) % 4];
        if (c >= 3 && (f == 13 || f == 15)) ib[0] = resp_e[c];
      end
    end
    return {4'(f), ib};
  endfunction : exp_word
  // one multiframe back to back, then drain
  task automatic send_mf();
    logic [15:0] r;
    for (int f = 0; f < 16; f++) begin
      r = rnd();
      tx_in_valid <= 1'b1;
      tx_in_frame <= 4'(f);
      in_bits <= r[4:0];
      exp_q.push_back(exp_word(f, r[4:0]));
      do @(posedge pclk); while (tx_in_ready !== 1'b1);
    end
    tx_in_valid <= 1'b0;
    while (exp_q.size() != 0) @(posedge pclk);
  endtask : send_mf
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // compare every word taken by the sink
  always @(posedge pclk) begin
    if (got_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0000_0001, 32'h0000_0000);
      else chk(32'(got_word), 32'(exp_q.pop_front()));
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] r;
    {psel, penable, pwrite, rx_ais_detect, rx_e_valid, rx_e_bit, rx_crc_err} <= '0;
    {tx_in_valid, stall_en, paddr, pwdata, tx_in_frame, in_bits} <= '0;
    {n_errors, checks_done, m_ctrl, m_sa4, m_ais, m_crc, m_febe} = '0;
    lfsr_q = 16'h6AC5;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(ba(`IDX_AUTO_CTRL), 32'h0000_0000, 1'b0);
    rdchk(ba(`IDX_SA4_PATTERN), 32'h0000_00FF, 1'b0);
    rdchk(ba(`IDX_LINK_CTRL), 32'h0000_0000, 1'b0);
    rdchk(ba(`IDX_SRC_SEL), 32'h0000_0000, 1'b0);
    wr(`IDX_RESP_STATUS, 32'h0000_00FF);
    rdchk(ba(`IDX_RESP_STATUS), 32'h0000_0000, 1'b0);
    rdchk(12'h000, 32'h0000_0000, 1'b1);
    rdchk(ba(`IDX_AUTO_CTRL) + 12'h001, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      m_ctrl = ctrl_tab[i] & `CTRL_WR_MASK;
      m_pat = r[7:0];
      m_sa4 = (i % 4 == 3);
      stall_en <= i[0];
      wr(`IDX_AUTO_CTRL, 32'(ctrl_tab[i]));
      wr(`IDX_SA4_PATTERN, 32'(r[7:0]));
      wr(`IDX_LINK_CTRL, 32'(i[0]));
      wr(`IDX_SRC_SEL, 32'(i[1]));
      rdchk(ba(`IDX_AUTO_CTRL), m_ctrl, 1'b0);
      rdchk(ba(`IDX_SA4_PATTERN), m_pat, 1'b0);
      set_trig(trig_tab[i]);
      rdchk(ba(`IDX_RESP_STATUS), m_crc * 32 + m_febe * 16 + m_ais * 8 + resp_code(), 1'b0);
      send_mf();
    end
    chk(exp_q.size(), 32'h0000_0000);
    // second reset restores the pattern register
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rdchk(ba(`IDX_SA4_PATTERN), 32'h0000_00FF, 1'b0);
    give_verdict();
  end
endmodule : tb_e1_sa_bit_auto_response
